// ===== shared/sar_adc_map.vh
// Constants for the successive-approximation converter sequencer
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

// Conversion timing in converter clock cycles
`define SAR_NORMAL_CYCLES 5'h0d
`define SAR_FIRST_CYCLES 5'h19
`define SAR_NORMAL_SAMPLE 5'h01
`define SAR_FIRST_SAMPLE 5'h0d

// Sequencer states
`define SAR_ST_IDLE 2'h0
`define SAR_ST_PEND 2'h1
`define SAR_ST_CONV 2'h2

// Trigger source code that selects the own completion flag
`define SAR_TRIG_FREE_RUN 3'h0

// Channel select codes: the last of the eight pins, then the codes beyond them
`define SAR_CH_PIN_LAST 4'h7
`define SAR_CH_BANDGAP 4'he
`define SAR_CH_GROUND 4'hf

// Reference select codes
`define SAR_REF_EXTERNAL 2'h0
`define SAR_REF_SUPPLY 2'h1
`define SAR_REF_RESERVED 2'h2
`define SAR_REF_INTERNAL 2'h3

// Reset values
`define SAR_RESET_CODE 10'h000
`define SAR_RESET_CHANNEL 4'h0
`define SAR_RESET_REFERENCE 2'h0

`endif

// ===== logic/sar_adc_sequencer.v
// Sequencer, prescaler, trigger logic and result registers of a 10-bit SAR converter
`timescale 1ns/1ps
`include "sar_adc_map.vh"
// Notes on behaviour
// - 10-bit result, right or left justified
// - Low byte read blocks result updates; results dropped
// - High byte read unblocks result updates
// - Done flag sets even when result dropped
// - Selections apply only while converter enabled
// - Start bit begins conversion, clears at end
// - Channel change waits for running conversion
// - Trigger rising edge resets prescaler, starts conversion
// - Edges during conversion and held levels ignored
// - Trigger flags set regardless of enables; software clears
// - Done flag source gives continuous conversion
// - Software start works in auto mode; busy reads one
// - Prescaler runs only while enabled, else reset
// - Software start waits for next converter clock edge
// - Normal conversion 13 cycles, first 25
// - Sample at 1.5 cycles, first at 13.5
// - Completion writes result, sets flag, clears start
// - Auto conversion samples at 2 cycles, lasts 13.5
// - Free running restarts at once, start bit stays
// - Selections track, freeze, resume in last cycle
module sar_adc_sequencer #(
    parameter RESULT_BITS = 10,
    parameter PRESC_BITS = 7,
    parameter TRIG_WIDTH = 8
) (
    input wire mclk,
    input wire rst_b,
    input wire converter_enable,
    input wire converter_power_gate,
    input wire left_adjust_result,
    input wire [2:0] prescaler_select,
    input wire auto_trigger_enable,
    input wire [2:0] trigger_source_select,
    input wire [3:0] channel_select,
    input wire [1:0] reference_select,
    input wire start_write,
    input wire done_flag_clear,
    input wire read_low_strobe,
    input wire read_high_strobe,
    input wire [TRIG_WIDTH-1:0] trigger_in,
    input wire comparator_above,
    output wire start_conversion,
    output reg conversion_done_flag,
    output reg [7:0] result_low_byte,
    output reg [7:0] result_high_byte,
    output reg result_locked,
    output reg [3:0] applied_channel,
    output reg [1:0] applied_reference,
    output reg [RESULT_BITS-1:0] dac_code,
    output reg sample_hold,
    output wire analog_power,
    output reg adc_clock
);

    reg [PRESC_BITS-1:0] presc_cnt;
    reg [1:0] state;
    reg [4:0] pos;
    reg first;
    reg auto_conv;
    reg trial_active;
    reg settle;
    reg [3:0] bit_idx;
    reg [RESULT_BITS-1:0] result_code;
    reg [TRIG_WIDTH-1:0] trig_meta;
    reg [TRIG_WIDTH-1:0] trig_sync;
    reg trig_prev;
    reg comp_meta;
    reg comp_sync;

    wire active;
    wire [PRESC_BITS:0] div;
    wire [PRESC_BITS-1:0] div_m1;
    wire [PRESC_BITS-1:0] half_m1;
    wire adc_tick;
    wire adc_half;
    wire trig_level;
    wire trig_edge;
    wire trig_start;
    wire free_run;
    wire in_conv;
    wire [4:0] sample_pos;
    wire [4:0] done_pos;
    wire sample_evt;
    wire done_evt;
    wire last_cycle;
    wire track;
    reg [3:0] legal_channel;
    reg [1:0] legal_reference;
    wire [15:0] left_word;
    wire [15:0] right_word;

    // Index of the first trial bit
    localparam [3:0] TOP_BIT = RESULT_BITS - 1;

    // Power gate set means the converter is treated as switched off
    assign active = converter_enable & ~converter_power_gate;
    assign analog_power = active;

    // Division factors 2,2,4,8,16,32,64,128
    assign div = {{PRESC_BITS{1'b0}}, 1'b1} << ((prescaler_select == 3'h0) ? 3'h1 : prescaler_select);
    assign div_m1 = div[PRESC_BITS-1:0] - {{(PRESC_BITS-1){1'b0}}, 1'b1};
    assign half_m1 = div[PRESC_BITS:1] - {{(PRESC_BITS-1){1'b0}}, 1'b1};
    assign adc_tick = active & (presc_cnt == div_m1);
    assign adc_half = active & (presc_cnt == half_m1);

    // Trigger pins and flags pass two flops; source zero is handled as free running
    assign trig_level = trig_sync[trigger_source_select];
    assign trig_edge = trig_level & ~trig_prev & (trigger_source_select != `SAR_TRIG_FREE_RUN);
    assign in_conv = (state == `SAR_ST_CONV);
    assign trig_start = active & auto_trigger_enable & trig_edge & ~in_conv;
    assign free_run = auto_trigger_enable & (trigger_source_select == `SAR_TRIG_FREE_RUN);

    assign sample_pos = first ? `SAR_FIRST_SAMPLE : `SAR_NORMAL_SAMPLE;
    assign done_pos = first ? `SAR_FIRST_CYCLES : `SAR_NORMAL_CYCLES;
    // Normal: sample at the half point of cycle 1 (or 13); auto: at the edge ending that cycle
    assign sample_evt = in_conv & (auto_conv ? (adc_tick & (pos == sample_pos))
                                             : (adc_half & (pos == sample_pos)));
    // Normal ends on the 13th (25th) edge; auto ends half a cycle later
    assign done_evt = in_conv & (auto_conv ? (adc_half & (pos == done_pos))
                                           : (adc_tick & (pos == done_pos - 5'h01)));
    assign last_cycle = in_conv & (pos >= done_pos - 5'h01);
    assign track = active & (~in_conv | last_cycle);

    // Unused channel codes fall back to ground so the input never floats
    always @* begin
        legal_channel = `SAR_CH_GROUND;
        case (channel_select)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                legal_channel = channel_select;
            end
            `SAR_CH_BANDGAP: begin
                legal_channel = `SAR_CH_BANDGAP;
            end
            default: begin
                legal_channel = `SAR_CH_GROUND;
            end
        endcase
    end

    // Reserved reference code falls back to the external pin
    always @* begin
        legal_reference = `SAR_REF_EXTERNAL;
        case (reference_select)
            `SAR_REF_SUPPLY: begin
                legal_reference = `SAR_REF_SUPPLY;
            end
            `SAR_REF_INTERNAL: begin
                legal_reference = `SAR_REF_INTERNAL;
            end
            `SAR_REF_RESERVED: begin
                legal_reference = `SAR_REF_EXTERNAL;
            end
            default: begin
                legal_reference = `SAR_REF_EXTERNAL;
            end
        endcase
    end

    assign start_conversion = (state != `SAR_ST_IDLE);

    assign left_word = {result_code, 6'h00};
    assign right_word = {6'h00, result_code};

    // Synchronisers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trig_meta <= {TRIG_WIDTH{1'b0}};
            trig_sync <= {TRIG_WIDTH{1'b0}};
            trig_prev <= 1'b0;
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            trig_meta <= trigger_in;
            trig_sync <= trig_meta;
            trig_prev <= trig_level;
            comp_meta <= comparator_above;
            comp_sync <= comp_meta;
        end
    end

    // Prescaler, held in reset while disabled and restarted by a trigger
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            presc_cnt <= {PRESC_BITS{1'b0}};
            adc_clock <= 1'b0;
        end else if (!active || trig_start) begin
            presc_cnt <= {PRESC_BITS{1'b0}};
            adc_clock <= 1'b0;
        end else begin
            if (adc_tick) begin
                presc_cnt <= {PRESC_BITS{1'b0}};
            end else begin
                presc_cnt <= presc_cnt + {{(PRESC_BITS-1){1'b0}}, 1'b1};
            end
            adc_clock <= (presc_cnt >= half_m1) & ~adc_tick;
        end
    end

    // Conversion sequencer
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= `SAR_ST_IDLE;
            pos <= 5'h00;
            first <= 1'b1;
            auto_conv <= 1'b0;
        end else if (!active) begin
            // Switching off aborts any conversion and re-arms the long first one
            state <= `SAR_ST_IDLE;
            pos <= 5'h00;
            first <= 1'b1;
            auto_conv <= 1'b0;
        end else begin
            case (state)
                `SAR_ST_IDLE: begin
                    if (trig_start) begin
                        state <= `SAR_ST_CONV;
                        pos <= 5'h00;
                        auto_conv <= 1'b1;
                    end else if (start_write) begin
                        state <= `SAR_ST_PEND;
                    end
                end
                `SAR_ST_PEND: begin
                    if (trig_start) begin
                        state <= `SAR_ST_CONV;
                        pos <= 5'h00;
                        auto_conv <= 1'b1;
                    end else if (adc_tick) begin
                        state <= `SAR_ST_CONV;
                        pos <= 5'h00;
                        auto_conv <= 1'b0;
                    end
                end
                `SAR_ST_CONV: begin
                    if (done_evt) begin
                        first <= 1'b0;
                        pos <= 5'h00;
                        auto_conv <= 1'b0;
                        if (free_run) begin
                            state <= `SAR_ST_CONV;
                        end else begin
                            state <= `SAR_ST_IDLE;
                        end
                    end else if (adc_tick) begin
                        pos <= pos + 5'h01;
                    end
                end
                default: begin
                    state <= `SAR_ST_IDLE;
                end
            endcase
        end
    end

    // Successive approximation; one bit per converter clock after sampling.
    // The comparator passes two flops, so the slowest prescaler settings suit best.
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dac_code <= `SAR_RESET_CODE;
            bit_idx <= 4'h0;
            trial_active <= 1'b0;
            sample_hold <= 1'b0;
            settle <= 1'b0;
        end else begin
            sample_hold <= sample_evt;
            if (!active || !in_conv) begin
                trial_active <= 1'b0;
                settle <= 1'b0;
            end else if (sample_evt) begin
                dac_code <= {1'b1, {(RESULT_BITS-1){1'b0}}};
                bit_idx <= TOP_BIT;
                trial_active <= 1'b1;
                // Held level plus two comparator flops outlast half a cycle; skip one tick
                settle <= 1'b1;
            end else if (trial_active && adc_tick) begin
                if (settle) begin
                    settle <= 1'b0;
                end else begin
                    dac_code[bit_idx] <= comp_sync;
                    if (bit_idx == 4'h0) begin
                        trial_active <= 1'b0;
                    end else begin
                        dac_code[bit_idx - 4'h1] <= 1'b1;
                        bit_idx <= bit_idx - 4'h1;
                    end
                end
            end
        end
    end

    // Result store, read-order lock and completion flag
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            result_code <= `SAR_RESET_CODE;
            result_locked <= 1'b0;
            conversion_done_flag <= 1'b0;
            result_low_byte <= 8'h00;
            result_high_byte <= 8'h00;
        end else begin
            if (done_evt && !result_locked) begin
                result_code <= dac_code;
            end
            if (read_high_strobe) begin
                result_locked <= 1'b0;
            end else if (read_low_strobe) begin
                result_locked <= 1'b1;
            end
            // Set wins over a clear in the same cycle
            if (done_evt) begin
                conversion_done_flag <= 1'b1;
            end else if (done_flag_clear) begin
                conversion_done_flag <= 1'b0;
            end
            if (left_adjust_result) begin
                result_low_byte <= left_word[7:0];
                result_high_byte <= left_word[15:8];
            end else begin
                result_low_byte <= right_word[7:0];
                result_high_byte <= right_word[15:8];
            end
        end
    end

    // Applied selections, buffered against changes mid-conversion
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            applied_channel <= `SAR_RESET_CHANNEL;
            applied_reference <= `SAR_RESET_REFERENCE;
        end else if (track) begin
            applied_channel <= legal_channel;
            applied_reference <= legal_reference;
        end
    end

endmodule // sar_adc_sequencer

// ===== verification/sar_adc_sequencer_chk.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_chk #(
    parameter RESULT_BITS = 10,
    parameter PRESC_BITS = 7,
    parameter TRIG_WIDTH = 8
) (
    input wire mclk,
    input wire rst_b,
    input wire converter_enable,
    input wire converter_power_gate,
    input wire left_adjust_result,
    input wire [2:0] prescaler_select,
    input wire auto_trigger_enable,
    input wire [2:0] trigger_source_select,
    input wire [3:0] channel_select,
    input wire [1:0] reference_select,
    input wire start_write,
    input wire done_flag_clear,
    input wire read_low_strobe,
    input wire read_high_strobe,
    input wire [TRIG_WIDTH-1:0] trigger_in,
    input wire comparator_above,
    input wire start_conversion,
    input wire conversion_done_flag,
    input wire [7:0] result_low_byte,
    input wire [7:0] result_high_byte,
    input wire result_locked,
    input wire [3:0] applied_channel,
    input wire [1:0] applied_reference,
    input wire [RESULT_BITS-1:0] dac_code,
    input wire sample_hold,
    input wire analog_power,
    input wire adc_clock
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire pwr = converter_enable && !converter_power_gate;
    wire free_mode = auto_trigger_enable && trigger_source_select == 3'h0 && pwr;
    sequence idle_start;
        start_write && pwr && !start_conversion;
    endsequence
    // Three cycles of lock cover a completion that landed just before the low read
    sequence lock_held;
        (result_locked && $stable(left_adjust_result))[*3];
    endsequence
    sequence trig_edge;
        auto_trigger_enable && trigger_source_select != 3'h0 && pwr && !start_conversion
            && $rose(trigger_in[trigger_source_select]);
    endsequence
    chk_start_taken: assert property (idle_start |=> start_conversion)
        else $error("start request not taken");
    chk_trig_start: assert property (trig_edge |-> ##[1:6] start_conversion)
        else $error("trigger edge did not start");
    chk_lock_blocks: assert property (lock_held |=> $stable({result_high_byte, result_low_byte}))
        else $error("result changed while locked");
    chk_high_unlocks: assert property (read_high_strobe |=> !result_locked)
        else $error("high read left lock set");
    chk_done_flag: assert property ($fell(start_conversion) && pwr && $past(pwr) |-> conversion_done_flag)
        else $error("completion without done flag");
    chk_sample_inside: assert property (sample_hold |-> start_conversion ##1 !sample_hold)
        else $error("sample pulse outside conversion");
    chk_sel_frozen: assert property (sample_hold |=> ($stable(applied_channel) && $stable(applied_reference))[*8])
        else $error("selection moved during conversion");
    chk_sel_disabled: assert property ((!converter_enable)[*3] |-> $stable(applied_channel))
        else $error("selection applied while disabled");
    chk_free_run: assert property (start_conversion && free_mode ##1 free_mode |-> start_conversion)
        else $error("start bit fell in free running");
    chk_clock_off: assert property (!analog_power |=> !adc_clock)
        else $error("converter clock ran while off");
endmodule // sar_adc_sequencer_chk

// ===== verification/analog_side.sv
// Analog side model: input pins, bandgap, ground and comparator
`timescale 1ns/1ps
module analog_side (
    input wire mclk,
    input wire rst_b,
    input wire analog_power,
    input wire sample_hold,
    input wire [3:0] applied_channel,
    input wire [9:0] dac_code,
    output wire comparator_above
);
    reg [9:0] held;
    // Inputs sit half a step above the level, so the ideal code is exact
    function [9:0] level(input [3:0] ch);
        level = ch < 4'h8 ? {ch[2:0], 7'h55} : (ch == 4'he ? 10'h160 : 10'h000);
    endfunction
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            held <= 10'h000;
        else if (sample_hold)
            held <= level(applied_channel);
    end
    assign comparator_above = analog_power && dac_code <= held;
endmodule // analog_side

// ===== verification/sar_adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_tb;
    reg mclk, rst_b, converter_enable, converter_power_gate, left_adjust_result, auto_trigger_enable;
    reg start_write, done_flag_clear, read_low_strobe, read_high_strobe;
    reg [2:0] prescaler_select, trigger_source_select;
    reg [3:0] channel_select;
    reg [1:0] reference_select;
    reg [7:0] trigger_in;
    wire comparator_above, start_conversion, conversion_done_flag, result_locked, sample_hold;
    wire analog_power, adc_clock;
    wire [7:0] result_low_byte, result_high_byte;
    wire [3:0] applied_channel;
    wire [1:0] applied_reference;
    wire [9:0] dac_code;
    integer fail_count, checked, n, i;
    reg [24:0] rows [0:5];
    sar_adc_sequencer sar_adc_sequencer_inst (.*);
    analog_side analog_side_inst (.*);
    task close_out;
        begin
            if (fail_count == 0 && checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [8*10:1] nm, input [15:0] e, input [15:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wait_sc(input v);
        begin
            n = 0;
            while (start_conversion !== v) begin
                @(posedge mclk);
                #1;
                n = n + 1;
                if (n == 150) begin
                    fail_count = fail_count + 1;
                    close_out;
                end
            end
        end
    endtask
    // Strobes: start, flag clear, low read, high read
    task pulse(input [3:0] m);
        begin
            @(posedge mclk);
            {start_write, done_flag_clear, read_low_strobe, read_high_strobe} <= m;
            @(posedge mclk);
            {start_write, done_flag_clear, read_low_strobe, read_high_strobe} <= 4'h0;
            #1;
        end
    endtask
    // Channel moves to mid 20 cycles after the start bit, after sampling except in a long first conversion; result bytes land one cycle after done
    task run(input [3:0] mid);
        begin
            pulse(4'h8);
            wait_sc(1'b1);
            repeat (20) @(posedge mclk);
            channel_select <= mid;
            wait_sc(1'b0);
            repeat (2) @(posedge mclk);
            #1;
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        {rst_b, converter_enable, converter_power_gate, left_adjust_result, auto_trigger_enable} = '0;
        {start_write, done_flag_clear, read_low_strobe, read_high_strobe, trigger_source_select} = '0;
        {channel_select, reference_select, trigger_in} = '0;
        prescaler_select = 3'h2;
        fail_count = 0;
        checked = 0;
        rows[0] = {1'b0, 4'h3, 2'h0, 2'h0, 16'h01d5};
        rows[1] = {1'b1, 4'h7, 2'h1, 2'h1, 16'hf540};
        rows[2] = {1'b0, 4'he, 2'h2, 2'h0, 16'h0160};
        rows[3] = {1'b1, 4'hf, 2'h3, 2'h3, 16'h0000};
        rows[4] = {1'b1, 4'h0, 2'h0, 2'h0, 16'h1540};
        rows[5] = {1'b0, 4'h5, 2'h3, 2'h3, 16'h02d5};
        repeat (10) @(posedge mclk);
        chk("reset", 16'h0, {1'b0, start_conversion, conversion_done_flag, result_locked, applied_channel, result_high_byte});
        rst_b <= 1'b1;
        channel_select <= 4'h3;
        pulse(4'h8);
        chk("off", 16'h0, {11'h0, start_conversion, applied_channel});
        @(posedge mclk);
        {converter_enable, converter_power_gate} <= 2'h3;
        pulse(4'h8);
        chk("gated", 16'h0, {14'h0, start_conversion, analog_power});
        @(posedge mclk);
        converter_power_gate <= 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge mclk);
            {left_adjust_result, channel_select, reference_select} <= rows[i][24:18];
            run(rows[i][23:20]);
            chk("length", 16'h1, {15'h0, n + 21 >= (i ? 52 : 100) && n + 21 <= (i ? 58 : 106)});
            chk("flag", 16'h1, {15'h0, conversion_done_flag});
            pulse(4'h6);
            pulse(4'h1);
            chk("result", rows[i][15:0], {result_high_byte, result_low_byte});
            chk("select", {10'h0, rows[i][23:20], rows[i][17:16]}, {10'h0, applied_channel, applied_reference});
        end
        pulse(4'h2);
        run(4'h7);
        chk("lock flag", 16'h1, {15'h0, conversion_done_flag});
        chk("locked", 16'h02d5, {result_high_byte, result_low_byte});
        pulse(4'h5);
        run(4'h7);
        chk("unlocked", 16'h03d5, {result_high_byte, result_low_byte});
        @(posedge mclk);
        channel_select <= 4'h0;
        run(4'h7);
        chk("old chan", 16'h0055, {result_high_byte, result_low_byte});
        chk("new chan", 16'h7, {12'h0, applied_channel});
        @(posedge mclk);
        {auto_trigger_enable, trigger_source_select, trigger_in} <= 12'h902;
        wait_sc(1'b1);
        chk("trig wait", 16'h1, {15'h0, n >= 2 && n <= 6});
        repeat (8) @(posedge mclk);
        trigger_in <= 8'h00;
        repeat (4) @(posedge mclk);
        trigger_in <= 8'h02;
        wait_sc(1'b0);
        repeat (30) @(posedge mclk);
        #1;
        chk("retrigger", 16'h0, {15'h0, start_conversion});
        @(posedge mclk);
        trigger_source_select <= 3'h0;
        pulse(4'h8);
        repeat (150) @(posedge mclk);
        #1;
        chk("free run", 16'h3, {14'h0, start_conversion, conversion_done_flag});
        pulse(4'h4);
        repeat (70) @(posedge mclk);
        #1;
        chk("free again", 16'h3, {14'h0, start_conversion, conversion_done_flag});
        @(posedge mclk);
        converter_enable <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("abort", 16'h0, {15'h0, start_conversion});
        close_out;
    end
endmodule // sar_adc_sequencer_tb
bind sar_adc_sequencer sar_adc_sequencer_chk #(.RESULT_BITS(RESULT_BITS), .PRESC_BITS(PRESC_BITS),
    .TRIG_WIDTH(TRIG_WIDTH)) chk_inst (.*);
